// file: vib_pkg.sv
// shared constants, types and register map for the vibration capture block
package vib_pkg;
  // register byte addresses on the serial link
  localparam logic [6:0] ADDR_CAPT_CFG = 7'h1c;
  localparam logic [6:0] ADDR_PERIOD   = 7'h1e;
  localparam logic [6:0] ADDR_THR_X    = 7'h20;
  localparam logic [6:0] ADDR_THR_Y    = 7'h22;
  localparam logic [6:0] ADDR_THR_Z    = 7'h24;
  localparam logic [6:0] ADDR_THR_SYS  = 7'h26;
  localparam logic [6:0] ADDR_ALARM_ENABLES_AND_SOURCE = 7'h28;
  localparam logic [6:0] ADDR_IO_CFG   = 7'h36;
  localparam logic [6:0] ADDR_DIAG     = 7'h3c;
  localparam logic [6:0] ADDR_CMD      = 7'h3e;
  localparam logic [6:0] ADDR_BUF_PTR  = 7'h0a;
  localparam logic [6:0] ADDR_EST_TIME = 7'h12;
  localparam logic [6:0] ADDR_BUF_X    = 7'h14;
  localparam logic [6:0] ADDR_BUF_Y    = 7'h16;
  localparam logic [6:0] ADDR_BUF_Z    = 7'h18;
  // values after reset
  localparam logic [15:0] RST_CAPT_CFG = 16'h0020;
  localparam logic [15:0] RST_ZERO     = 16'h0000;
  localparam logic [15:0] RST_IO_CFG   = 16'h000f;
  // field positions
  localparam int CFG_PWRDN  = 1;
  localparam int CFG_MODE   = 2;
  localparam int CFG_PRE    = 4;
  localparam int CFG_BACKUP = 6;
  localparam int CFG_AXIS   = 8;
  localparam int ALM_SRC    = 4;
  localparam int ALM_POL    = 5;
  localparam int DIAG_FLAG  = 8;
  localparam int CMD_SLEEP  = 1;
  localparam int CMD_CLEAR  = 4;
  localparam int CMD_START  = 11;
  localparam int CMD_RESTORE = 13;
  localparam int IO1_FUNC   = 2;
  localparam int IO2_FUNC   = 4;
  // encodings
  localparam logic [1:0] MODE_EVENT = 2'h2;
  localparam logic [1:0] MODE_EXT   = 2'h3;
  localparam logic [1:0] FUNC_ALARM = 2'h1;
  localparam logic [1:0] FUNC_TRIG  = 2'h2;
  localparam logic [1:0] FUNC_BUSY  = 2'h3;
  localparam logic [9:0] PRE_BASE   = 10'h040;
  localparam logic [9:0] LAST_IDX   = 10'h3ff;
  localparam logic [1:0] LAST_BUF   = 2'h2;
  // timing
  localparam int SYS_CLK_MHZ     = 200;
  localparam int WAKE_TIME_US    = 2500;
  localparam int WAKE_CYCLES     = WAKE_TIME_US * SYS_CLK_MHZ;
  localparam int TRIG_MIN_NS     = 2600;
  localparam int TRIG_MIN_CYCLES = (TRIG_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
  // capture time estimate, ms; block time is 1024/70700 s in 1/1024 ms units
  localparam logic [31:0] EST_BASE_MS       = 32'd14;
  localparam logic [31:0] EST_BASE_FLASH_MS = 32'd516;
  localparam logic [31:0] EST_BLOCK_Q10     = 32'd14831;
  typedef enum {ST_IDLE, ST_FILL, ST_PRE, ST_POST, ST_BACKUP, ST_RESTORE,
                ST_SLEEP, ST_WAKE} cap_state_type;
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [11:0] temp;
    logic [11:0] supply;
  } sample_type;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [15:0] data;
  } flash_cmd_type;
endpackage

// file: vib_capture.sv
// capture sequencing, alarms, serial register port and sample fifo
`timescale 1ns/1ps

module sample_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module vib_capture #(
  parameter int WAKE_COUNT = vib_pkg::WAKE_CYCLES,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  input  wire logic                   cs_n,
  input  wire logic                   sclk,
  input  wire logic                   din,
  output logic                        dout,
  output logic                        dout_oe,
  input  wire logic                   io_line_one_in,
  output logic                        io_line_one_out,
  output logic                        io_line_one_oe,
  input  wire logic                   io_line_two_in,
  output logic                        io_line_two_out,
  output logic                        io_line_two_oe,
  input  wire vib_pkg::sample_type    sample_in,
  input  wire logic                   sample_valid,
  output logic                        sample_ready,
  input  wire logic [3:0]             averaging_count,
  output vib_pkg::flash_cmd_type      flash_cmd,
  input  wire logic [15:0]            flash_rdata,
  output logic                        asleep
);
  import vib_pkg::*;

  logic [15:0]   capture_configuration;
  logic [15:0]   capture_repeat_period;
  logic [15:0]   x_axis_threshold;
  logic [15:0]   y_axis_threshold;
  logic [15:0]   z_axis_threshold;
  logic [15:0]   system_threshold;
  logic [15:0]   alarm_enables_and_source;
  logic [15:0]   io_line_function_config;
  logic [3:0]    alarm_flags;
  logic [9:0]    buf_ptr;
  logic [15:0]   cmd;
  cap_state_type state;
  logic [15:0]   mem [0:2][0:1023];

  // pin synchronisers: three stages, a change counts once stages two and three agree
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [4:0] pins;
  logic [4:0] pins_d;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sync1  <= 5'h03;
      sync2  <= 5'h03;
      sync3  <= 5'h03;
      pins   <= 5'h03;
      pins_d <= 5'h03;
    end else begin
      sync1  <= {io_line_two_in, io_line_one_in, din, sclk, cs_n};
      sync2  <= sync1;
      sync3  <= sync2;
      pins   <= (sync2 & sync3) | (pins & (sync2 ^ sync3));
      pins_d <= pins;
    end
  end
  logic cs_low;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  assign cs_low    = !pins[0];
  assign cs_fall   = pins_d[0] && !pins[0];
  assign sclk_rise = !pins_d[1] && pins[1];
  assign sclk_fall = pins_d[1] && !pins[1];

  // serial frames: bit 15 write flag, [14:8] address, [7:0] data
  logic [15:0] shift_in;
  logic [15:0] shift_out;
  logic [15:0] read_word;
  logic [6:0]  read_addr;
  logic [3:0]  bit_count;
  logic        frame_bad;
  logic        frame_done;
  logic        read_pend;
  logic [15:0] frame;
  assign frame = {shift_in[14:0], pins[2]};
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      shift_in   <= '0;
      shift_out  <= '0;
      bit_count  <= '0;
      frame_bad  <= 1'b0;
      frame_done <= 1'b0;
      dout       <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (cs_fall) begin
        bit_count <= '0;
        frame_bad <= (state == ST_SLEEP) || (state == ST_WAKE);
        shift_out <= read_word;
        dout      <= read_word[15];
      end else if (cs_low && sclk_rise) begin
        shift_in  <= frame;
        bit_count <= bit_count + 1'b1;
        frame_done <= (bit_count == 4'hf) && !frame_bad && (state != ST_WAKE);
      end else if (cs_low && sclk_fall) begin
        // first fall puts the msb out again, so the host finds it at the first rise
        shift_out <= {shift_out[14:0], 1'b0};
        dout      <= shift_out[15];
      end
    end
  end
  assign dout_oe = cs_low;

  logic       wr_frame;
  logic [6:0] fr_addr;
  logic [7:0] fr_data;
  assign wr_frame = frame_done && shift_in[15];
  assign fr_addr  = shift_in[14:8];
  assign fr_data  = shift_in[7:0];

  // byte write into a 16-bit register, odd address is the upper byte
  function automatic logic [15:0] put_byte(input logic [15:0] old, input logic [6:0] a,
                                           input logic [7:0] d);
    put_byte = a[0] ? {d, old[7:0]} : {old[15:8], d};
  endfunction

  // configuration registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      capture_configuration    <= RST_CAPT_CFG;
      capture_repeat_period    <= RST_ZERO;
      x_axis_threshold         <= RST_ZERO;
      y_axis_threshold         <= RST_ZERO;
      z_axis_threshold         <= RST_ZERO;
      system_threshold         <= RST_ZERO;
      alarm_enables_and_source <= RST_ZERO;
      io_line_function_config  <= RST_IO_CFG;
    end else if (wr_frame) begin
      case ({fr_addr[6:1], 1'b0})
        ADDR_CAPT_CFG: capture_configuration <= put_byte(capture_configuration, fr_addr, fr_data);
        ADDR_PERIOD:   capture_repeat_period <= put_byte(capture_repeat_period, fr_addr, fr_data);
        ADDR_THR_X:    x_axis_threshold <= put_byte(x_axis_threshold, fr_addr, fr_data);
        ADDR_THR_Y:    y_axis_threshold <= put_byte(y_axis_threshold, fr_addr, fr_data);
        ADDR_THR_Z:    z_axis_threshold <= put_byte(z_axis_threshold, fr_addr, fr_data);
        ADDR_THR_SYS:  system_threshold <= put_byte(system_threshold, fr_addr, fr_data);
        ADDR_ALARM_ENABLES_AND_SOURCE: alarm_enables_and_source <=
                         put_byte(alarm_enables_and_source, fr_addr, fr_data);
        ADDR_IO_CFG:   io_line_function_config <=
                         put_byte(io_line_function_config, fr_addr, fr_data);
        default:       ;
      endcase
    end
  end

  // one-shot command bits, live for a single cycle and read back as zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cmd <= '0;
    end else if (wr_frame && ({fr_addr[6:1], 1'b0} == ADDR_CMD)) begin
      cmd <= fr_addr[0] ? {fr_data, 8'h00} : {8'h00, fr_data};
    end else begin
      cmd <= '0;
    end
  end

  // capture-time estimate in ms
  logic [31:0] est_ms;
  assign est_ms = (capture_configuration[CFG_BACKUP] ? EST_BASE_FLASH_MS : EST_BASE_MS)
                + ((EST_BLOCK_Q10 << averaging_count) >> 10);

  // read data is prepared after a read frame and shifted out on the next frame
  logic [1:0] rd_buf;
  assign rd_buf = (read_addr == ADDR_BUF_X) ? 2'h0 : (read_addr == ADDR_BUF_Y) ? 2'h1 : 2'h2;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      read_addr <= '0;
      read_pend <= 1'b0;
      read_word <= '0;
    end else begin
      read_pend <= frame_done && !shift_in[15];
      if (frame_done && !shift_in[15]) read_addr <= {fr_addr[6:1], 1'b0};
      if (read_pend) begin
        case (read_addr)
          ADDR_CAPT_CFG: read_word <= capture_configuration;
          ADDR_PERIOD:   read_word <= capture_repeat_period;
          ADDR_THR_X:    read_word <= x_axis_threshold;
          ADDR_THR_Y:    read_word <= y_axis_threshold;
          ADDR_THR_Z:    read_word <= z_axis_threshold;
          ADDR_THR_SYS:  read_word <= system_threshold;
          ADDR_ALARM_ENABLES_AND_SOURCE: read_word <= alarm_enables_and_source;
          ADDR_IO_CFG:   read_word <= io_line_function_config;
          ADDR_DIAG:     read_word <= {4'h0, alarm_flags, 8'h00};
          ADDR_BUF_PTR:  read_word <= {6'h00, buf_ptr};
          ADDR_EST_TIME: read_word <= est_ms[15:0];
          ADDR_BUF_X, ADDR_BUF_Y, ADDR_BUF_Z: read_word <= mem[rd_buf][buf_ptr];
          default:       read_word <= '0;
        endcase
      end
    end
  end

  // readout pointer: reading the z buffer steps to the next sample
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      buf_ptr <= '0;
    end else if (wr_frame && (fr_addr == ADDR_BUF_PTR)) begin
      buf_ptr <= {buf_ptr[9:8], fr_data};
    end else if (wr_frame && (fr_addr == (ADDR_BUF_PTR + 7'h01))) begin
      buf_ptr <= {fr_data[1:0], buf_ptr[7:0]};
    end else if (read_pend && (read_addr == ADDR_BUF_Z)) begin
      buf_ptr <= buf_ptr + 1'b1;
    end
  end

  // trigger pin: active level must last the least width, fires on its end
  logic [1:0] io1_func;
  logic [1:0] io2_func;
  logic       trig_level;
  logic       trig_level_d;
  logic [15:0] trig_width;
  logic       trig_pulse;
  assign io1_func   = io_line_function_config[IO1_FUNC +: 2];
  assign io2_func   = io_line_function_config[IO2_FUNC +: 2];
  assign trig_level = ((io1_func == FUNC_TRIG) && (pins[3] == io_line_function_config[0]))
                   || ((io2_func == FUNC_TRIG) && (pins[4] == io_line_function_config[1]));
  assign trig_pulse = trig_level_d && !trig_level && (trig_width >= 16'(TRIG_MIN_CYCLES));
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      trig_level_d <= 1'b0;
      trig_width   <= '0;
    end else begin
      trig_level_d <= trig_level;
      if (!trig_level) trig_width <= '0;
      else if (trig_width != 16'hffff) trig_width <= trig_width + 1'b1;
    end
  end

  // sample path through the fifo; the writer stalls while buffers are swept, asleep or waking
  sample_type smp;
  logic       smp_valid;
  logic       smp_take;
  logic       drain_ok;
  assign drain_ok = (state != ST_BACKUP) && (state != ST_RESTORE)
                 && (state != ST_SLEEP) && (state != ST_WAKE);
  assign smp_take = smp_valid && drain_ok;
  sample_fifo #(.WIDTH($bits(sample_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_data   (sample_in),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (smp),
    .out_valid (smp_valid),
    .out_ready (drain_ok)
  );

  // alarm checks: axis magnitude against signed threshold, system by polarity
  function automatic logic over_mag(input logic [15:0] s, input logic [15:0] t);
    logic signed [16:0] mag;
    mag = s[15] ? -17'(signed'(s)) : 17'(signed'(s));
    over_mag = mag > 17'(signed'(t));
  endfunction
  logic [11:0] sys_meas;
  logic [3:0]  trip;
  assign sys_meas = alarm_enables_and_source[ALM_SRC] ? smp.temp : smp.supply;
  always_comb begin
    trip[0] = alarm_enables_and_source[0] && over_mag(smp.x, x_axis_threshold);
    trip[1] = alarm_enables_and_source[1] && over_mag(smp.y, y_axis_threshold);
    trip[2] = alarm_enables_and_source[2] && over_mag(smp.z, z_axis_threshold);
    trip[3] = alarm_enables_and_source[3] && (alarm_enables_and_source[ALM_POL]
              ? (sys_meas < system_threshold[11:0])
              : (sys_meas > system_threshold[11:0]));
  end

  // sticky alarm flags, a new trip wins over the clear command
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      alarm_flags <= '0;
    end else begin
      alarm_flags <= (cmd[CMD_CLEAR] ? 4'h0 : alarm_flags)
                   | (smp_take ? trip : 4'h0);
    end
  end

  // capture sequencing
  logic [1:0]  mode;
  logic [9:0]  pre_mask;
  logic [9:0]  wr_idx;
  logic [1:0]  wr_buf;
  logic [11:0] sweep;
  logic [11:0] rs_addr;
  logic        rs_valid;
  logic [31:0] wake_count;
  logic        start;
  logic        cap_done;
  logic        sweep_end;
  assign mode      = capture_configuration[CFG_MODE +: 2];
  assign pre_mask  = (PRE_BASE << capture_configuration[CFG_PRE +: 2]) - 10'h001;
  assign start     = cmd[CMD_START] || trig_pulse;
  assign sweep_end = (sweep[11:10] == LAST_BUF) && (sweep[9:0] == LAST_IDX);
  assign cap_done  = smp_take && (wr_idx == LAST_IDX) && ((state == ST_POST)
                   || ((state == ST_FILL) && ((mode != MODE_EXT) || (wr_buf == LAST_BUF))));

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state      <= ST_IDLE;
      wr_idx     <= '0;
      wr_buf     <= '0;
      sweep      <= '0;
      wake_count <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          wr_idx <= '0;
          wr_buf <= '0;
          sweep  <= '0;
          if (start) state <= (mode == MODE_EVENT) ? ST_PRE : ST_FILL;
          else if (cmd[CMD_RESTORE]) state <= ST_RESTORE;
          else if (cmd[CMD_SLEEP]) state <= ST_SLEEP;
        end
        ST_FILL, ST_PRE, ST_POST: begin
          if (start) begin
            state <= ST_IDLE;
          end else if (cap_done) begin
            if (capture_configuration[CFG_BACKUP]) state <= ST_BACKUP;
            else if (capture_configuration[CFG_PWRDN]) state <= ST_SLEEP;
            else state <= ST_IDLE;
          end else if (smp_take) begin
            if (state == ST_PRE && |trip) begin
              state  <= ST_POST;
              wr_idx <= pre_mask + 10'h001;
            end else if (state == ST_PRE) begin
              wr_idx <= (wr_idx + 10'h001) & pre_mask;
            end else begin
              wr_idx <= wr_idx + 10'h001;
              if (wr_idx == LAST_IDX) wr_buf <= wr_buf + 2'h1;
            end
          end
        end
        ST_BACKUP: begin
          sweep <= sweep + 12'h001;
          if (sweep_end) state <= capture_configuration[CFG_PWRDN] ? ST_SLEEP : ST_IDLE;
        end
        ST_RESTORE: begin
          if (!sweep_end) sweep <= sweep + 12'h001;
          else if (rs_valid && (rs_addr == sweep)) state <= ST_IDLE;
        end
        ST_SLEEP: begin
          wake_count <= '0;
          if (cs_fall || trig_pulse) state <= ST_WAKE;
        end
        ST_WAKE: begin
          wake_count <= wake_count + 32'h1;
          if (wake_count >= 32'(WAKE_COUNT - 1)) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // restore pipeline: flash answers one cycle after the read request
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rs_valid <= 1'b0;
      rs_addr  <= '0;
    end else begin
      rs_valid <= flash_cmd.rd;
      rs_addr  <= flash_cmd.addr;
    end
  end

  // flash port: backup writes read the buffer one word per cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flash_cmd <= '0;
    end else begin
      flash_cmd.wr   <= (state == ST_BACKUP);
      // the last word is requested once, then the port goes quiet until restore ends
      flash_cmd.rd   <= (state == ST_RESTORE) && !(sweep_end && (flash_cmd.addr == sweep));
      flash_cmd.addr <= sweep;
      flash_cmd.data <= mem[sweep[11:10]][sweep[9:0]];
    end
  end

  // capture buffers; extended mode stores the chosen axis across all three
  logic [15:0] ext_sample;
  always_comb begin
    case (capture_configuration[CFG_AXIS +: 2])
      2'h0:    ext_sample = smp.x;
      2'h1:    ext_sample = smp.y;
      default: ext_sample = smp.z;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (state == ST_RESTORE && rs_valid) begin
      mem[rs_addr[11:10]][rs_addr[9:0]] <= flash_rdata;
    end else if (smp_take && (state == ST_FILL) && (mode == MODE_EXT)) begin
      mem[wr_buf][wr_idx] <= ext_sample;
    end else if (smp_take && ((state == ST_FILL) || (state == ST_PRE) || (state == ST_POST))) begin
      mem[0][wr_idx] <= smp.x;
      mem[1][wr_idx] <= smp.y;
      mem[2][wr_idx] <= smp.z;
    end
  end

  // indicator lines: alarm and busy outputs with per-line polarity
  logic busy;
  logic alarm_any;
  assign busy      = (state != ST_IDLE) && (state != ST_SLEEP);
  assign alarm_any = |alarm_flags;
  assign asleep    = (state == ST_SLEEP);
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      io_line_one_out <= 1'b0;
      io_line_two_out <= 1'b0;
      io_line_one_oe  <= 1'b0;
      io_line_two_oe  <= 1'b0;
    end else begin
      io_line_one_oe  <= (io1_func == FUNC_ALARM) || (io1_func == FUNC_BUSY);
      io_line_two_oe  <= (io2_func == FUNC_ALARM) || (io2_func == FUNC_BUSY);
      io_line_one_out <= ((io1_func == FUNC_ALARM) ? alarm_any : busy)
                         == io_line_function_config[0];
      io_line_two_out <= ((io2_func == FUNC_ALARM) ? alarm_any : busy)
                         == io_line_function_config[1];
    end
  end
endmodule

// file: vib_checker.sv
// port assertions for the capture block
`timescale 1ns/1ps
module vib_checker (
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  input wire logic                   cs_n,
  input wire vib_pkg::flash_cmd_type flash_cmd,
  input wire logic                   asleep
);
  import vib_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // sync stages need a few cycles before a wake can land
  property p_wake_cs; asleep && $fell(cs_n) ##1 !cs_n [*5] |-> !asleep; endproperty
  a_wake_cs: assert property (p_wake_cs) else $error("no wake on select");
  property p_stay_awake; $fell(asleep) |-> !asleep [*8]; endproperty
  a_stay_awake: assert property (p_stay_awake) else $error("slept again");
  // the flash port is registered, so the last backup word may share the first sleep cycle
  property p_no_wr_asleep; asleep |=> !flash_cmd.wr; endproperty
  a_no_wr_asleep: assert property (p_no_wr_asleep) else $error("write asleep");
  property p_wr_first; $rose(flash_cmd.wr) |-> flash_cmd.addr == 12'h000; endproperty
  a_wr_first: assert property (p_wr_first) else $error("backup start addr");
  property p_wr_step;
    flash_cmd.wr && $past(flash_cmd.wr) |-> flash_cmd.addr == $past(flash_cmd.addr) + 12'h001;
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("backup addr step");
  property p_wr_last; flash_cmd.wr && flash_cmd.addr == 12'hbff |=> !flash_cmd.wr; endproperty
  a_wr_last: assert property (p_wr_last) else $error("backup overrun");
  property p_excl; !(flash_cmd.wr && flash_cmd.rd); endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  property p_rd_first; $rose(flash_cmd.rd) |-> flash_cmd.addr == 12'h000; endproperty
  a_rd_first: assert property (p_rd_first) else $error("restore start addr");
endmodule
bind vib_capture vib_checker chk_i (.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n),
  .flash_cmd(flash_cmd), .asleep(asleep));

// file: spi_host.sv
// host model: serial master, clock idle high and still between frames
`timescale 1ns/1ps
module spi_host (
  input wire logic sys_clk,
  output logic     cs_n = 1'b1,
  output logic     sclk = 1'b1,
  output logic     din = 1'b0,
  input wire logic dout
);
  // one 16-bit frame, msb first, 160 ns link period
  task automatic frame(input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    @(posedge sys_clk) cs_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      din <= w[i];
      repeat (16) @(posedge sys_clk);
      sclk <= 1'b1;
      r[i] = dout;
      repeat (16) @(posedge sys_clk);
    end
    din <= ~w[0];
    cs_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
  endtask
  // waking frame is thrown away, then recovery time (scaled)
  // only one device shares this data line, so no select staggering
  task automatic wake;
    logic [15:0] r;
    frame(16'h0000, r);
    repeat (60) @(posedge sys_clk);
  endtask
endmodule

// file: tb_top.sv
// self-checking bench for the capture block
`timescale 1ns/1ps
module tb_top;
  import vib_pkg::*;
  logic          sys_clk = 1'b0, resetn = 1'b0, sample_valid = 1'b0;
  logic          cs_n, sclk, din, dout, dout_oe, sample_ready, asleep, io1, io1_oe;
  sample_type    sample_in = '0;
  flash_cmd_type flash_cmd;
  int            bad_count = 0, checks = 0, cycles = 0, wrs = 0;
  logic [15:0]   v, flash_q;
  always #2.5 sys_clk = ~sys_clk;
  spi_host host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
  vib_capture #(.WAKE_COUNT(50)) dut (.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n),
    .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe), .io_line_one_in(1'b0),
    .io_line_one_out(io1), .io_line_one_oe(io1_oe), .io_line_two_in(1'b0), .io_line_two_out(),
    .io_line_two_oe(), .sample_in(sample_in), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .averaging_count(4'h0), .flash_cmd(flash_cmd),
    .flash_rdata(flash_q), .asleep(asleep));
  // flash partner: answers a cycle after the request with a word made from the address
  always @(posedge sys_clk) flash_q <= {4'ha, flash_cmd.addr};
  task automatic summarize;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard and backup write count
  always @(posedge sys_clk) begin
    cycles++;
    if (flash_cmd.wr === 1'b1) wrs++;
    if (cycles == 60000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // registers go byte by byte, low byte first
  task automatic wr16(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] r;
    host.frame({1'b1, a, d[7:0]}, r);
    host.frame({1'b1, a | 7'h01, d[15:8]}, r);
  endtask
  // read answer comes back during the following frame
  task automatic rd16(input logic [6:0] a, output logic [15:0] d);
    logic [15:0] r;
    host.frame({1'b0, a, 8'h00}, r);
    host.frame(16'h0000, d);
  endtask
  task automatic push(input sample_type s);
    sample_in <= s;
    sample_valid <= 1'b1;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic t_regs;
    rd16(ADDR_CAPT_CFG, v);
    chk("capture_configuration", 16'h0020, v);
    rd16(ADDR_ALARM_ENABLES_AND_SOURCE, v);
    chk("alarm_enables_and_source", 16'h0000, v);
  endtask
  // negative x beyond threshold, y and z huge but disabled
  task automatic t_axis;
    wr16(ADDR_THR_X, 16'h1063);
    wr16(ADDR_ALARM_ENABLES_AND_SOURCE, 16'h0001);
    push('{16'hef9c, 16'h7fff, 16'h7fff, 12'h000, 12'h000});
    rd16(ADDR_DIAG, v);
    chk("axis_flags", 16'h0100, v);
    wr16(ADDR_CMD, 16'h0010);
    rd16(ADDR_DIAG, v);
    chk("flags_cleared", 16'h0000, v);
  endtask
  // temperature below threshold with below-trip polarity
  task automatic t_sys;
    wr16(ADDR_THR_SYS, 16'h0573);
    wr16(ADDR_ALARM_ENABLES_AND_SOURCE, 16'h0038);
    push('{16'h0000, 16'h0000, 16'h0000, 12'h572, 12'hfff});
    rd16(ADDR_DIAG, v);
    chk("system_flag", 16'h0800, v);
    wr16(ADDR_ALARM_ENABLES_AND_SOURCE, 16'h0000);
    wr16(ADDR_CMD, 16'h0010);
  endtask
  task automatic t_sleep;
    // low byte only: a second frame would already wake the device
    host.frame({1'b1, ADDR_CMD, 8'h02}, v);
    chk("asleep", 16'h0001, {15'h0000, asleep});
    host.wake();
    chk("awake", 16'h0000, {15'h0000, asleep});
  endtask
  // manual capture with backup then sleep, then restore
  task automatic t_backup;
    wr16(ADDR_CAPT_CFG, 16'h0042);
    wr16(ADDR_CMD, 16'h0800);
    sample_valid <= 1'b1;
    for (int i = 0; i < 9000 && asleep !== 1'b1; i++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    sample_valid <= 1'b0;
    chk("flash_writes", 16'd3072, wrs[15:0]);
    chk("sleep_after", 16'h0001, {15'h0000, asleep});
    host.wake();
    wr16(ADDR_CMD, 16'h2000);
    repeat (4000) @(posedge sys_clk);
    rd16(ADDR_BUF_X, v);
    chk("restored", 16'ha000, v);
  endtask
  // event mode, 64 pre samples: an x trip stops wrapping, post data starts at 64
  task automatic t_event;
    wr16(ADDR_CAPT_CFG, 16'h0008);
    wr16(ADDR_ALARM_ENABLES_AND_SOURCE, 16'h0001);
    wr16(ADDR_CMD, 16'h0800);
    sample_in <= '{16'h0001, 16'h0000, 16'h0000, 12'h000, 12'h000};
    sample_valid <= 1'b1;
    repeat (100) @(posedge sys_clk);
    chk("busy", 16'h0001, {15'h0000, io1});
    sample_in.x <= 16'h7000;
    @(posedge sys_clk);
    sample_in.x <= 16'h0002;
    repeat (1100) @(posedge sys_clk);
    sample_valid <= 1'b0;
    chk("capture_end", 16'h0000, {15'h0000, io1});
    wr16(ADDR_BUF_PTR, 16'h0040);
    rd16(ADDR_BUF_X, v);
    chk("first_post", 16'h0002, v);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge sys_clk);
    t_regs();
    t_axis();
    t_sys();
    t_sleep();
    t_backup();
    t_event();
    summarize();
  end
endmodule
